// ===== src/isevg_top.sv
// Status event logic: instrument-condition and standard event groups.
// Assumes commands arrive one per cycle from a remote command decoder.
module isevg_top #(
   parameter int CW = isevg_pkg::COND_W,
   parameter int SW = isevg_pkg::STD_W
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire isevg_pkg::isevg_cmd_s cmd_i,
   input wire logic clear_status_i,
   input wire logic device_clear_i,
   input wire logic reset_cmd_i,
   input wire logic power_on_clear_i,
   input wire isevg_pkg::isevg_cond_s cond_i,
   output logic [CW-1:0] rdata_o,
   output logic rvalid_o,
   output logic [7:0] summary_o,
   output logic err_push_o,
   output logic [SW-1:0] err_code_o
);

   logic [CW-1:0] cond_set;
   logic [CW-1:0] cond_event;
   logic [CW-1:0] cond_enable;
   logic cond_sum;
   logic [SW-1:0] std_set;
   logic [SW-1:0] std_event;
   logic [SW-1:0] std_enable;
   logic std_sum;
   logic pon_pending_q;
   logic pon_seen_q;
   logic cond_rd;
   logic std_rd;
   logic cond_clr;
   logic std_clr;
   logic cond_en_wr;
   logic std_en_wr;
   logic std_en_pon_clr;
   logic [CW-1:0] rdata_d;

   // Checks whether a command addresses a given register.
   function automatic logic hit(input isevg_pkg::isevg_cmd_s c, input isevg_pkg::isevg_sel_e s,
                                input logic rd);
      hit = (rd ? c.read : c.write) && (c.sel == s);
   endfunction : hit

   // Decode of command strobes; reset and device clear do not touch events.
   assign cond_rd = hit(cmd_i, isevg_pkg::ISEVG_SEL_COND_EVENT, 1'b1);
   assign std_rd = hit(cmd_i, isevg_pkg::ISEVG_SEL_STD_EVENT, 1'b1);
   assign cond_clr = cond_rd | clear_status_i;
   assign std_clr = std_rd | clear_status_i;
   assign cond_en_wr = hit(cmd_i, isevg_pkg::ISEVG_SEL_COND_ENABLE, 1'b0);
   assign std_en_wr = hit(cmd_i, isevg_pkg::ISEVG_SEL_STD_ENABLE, 1'b0);

   // Instrument-condition set pulses placed at their bit positions.
   always_comb
   begin
      cond_set = '0;
      cond_set[isevg_pkg::COND_VREG_BIT] = cond_i.volt_unreg;
      cond_set[isevg_pkg::COND_IREG_BIT] = cond_i.curr_unreg;
      cond_set[isevg_pkg::COND_FAN_BIT] = cond_i.fan_fault;
      cond_set[isevg_pkg::COND_OVP_BIT] = cond_i.ovp_trip;
   end

   // Standard event set pulses, including the one-time power-on mark.
   always_comb
   begin
      std_set = '0;
      std_set[isevg_pkg::STD_OPC_BIT] = cond_i.op_complete;
      std_set[isevg_pkg::STD_QRY_BIT] = cond_i.query_err;
      std_set[isevg_pkg::STD_DEV_BIT] = cond_i.device_err;
      std_set[isevg_pkg::STD_EXE_BIT] = cond_i.exec_err;
      std_set[isevg_pkg::STD_CMD_BIT] = cond_i.cmd_err;
      std_set[isevg_pkg::STD_PON_BIT] = pon_pending_q;
   end

   // The first cycle after power-on reset raises the power-on event once.
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         pon_pending_q <= 1'b1;
         pon_seen_q <= 1'b0;
      end
      else
      begin
         pon_pending_q <= 1'b0;
         pon_seen_q <= 1'b1;
      end
   end

   // Power-on clears the standard enable only when the retained setting is 1.
   assign std_en_pon_clr = pon_pending_q && power_on_clear_i;

   // Instrument-condition group.
   isevg_group #(
      .WIDTH(CW),
      .USED(isevg_pkg::COND_USED_MASK)
   ) u_cond (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .set_i(cond_set),
      .clear_i(cond_clr),
      .en_wr_i(cond_en_wr),
      .en_wdata_i(cmd_i.wdata),
      .en_clr_i(1'b0),
      .event_o(cond_event),
      .enable_o(cond_enable),
      .summary_o(cond_sum)
   );

   // Standard event group.
   isevg_group #(
      .WIDTH(SW),
      .USED(isevg_pkg::STD_USED_MASK)
   ) u_std (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .set_i(std_set),
      .clear_i(std_clr),
      .en_wr_i(std_en_wr),
      .en_wdata_i(cmd_i.wdata[SW-1:0]),
      .en_clr_i(std_en_pon_clr),
      .event_o(std_event),
      .enable_o(std_enable),
      .summary_o(std_sum)
   );

   // Read data mux; the binary value is the weighted sum of set bits.
   always_comb
   begin
      rdata_d = '0;
      case (cmd_i.sel)
         isevg_pkg::ISEVG_SEL_COND_EVENT: rdata_d = cond_event;
         isevg_pkg::ISEVG_SEL_COND_ENABLE: rdata_d = cond_enable;
         isevg_pkg::ISEVG_SEL_STD_EVENT: rdata_d = {{(CW-SW){1'b0}}, std_event};
         isevg_pkg::ISEVG_SEL_STD_ENABLE: rdata_d = {{(CW-SW){1'b0}}, std_enable};
         default: rdata_d = '0;
      endcase
   end

   // Registered read answer, one cycle after the query.
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= '0;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rdata_o <= cmd_i.read ? rdata_d : '0;
         rvalid_o <= cmd_i.read;
      end
   end

   // Summary bits registered into the status summary positions.
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         summary_o <= '0;
      else
      begin
         summary_o <= '0;
         summary_o[isevg_pkg::SUM_COND_BIT] <= cond_sum;
         summary_o[isevg_pkg::SUM_STD_BIT] <= std_sum;
      end
   end

   // Error events push one error queue entry per cycle, carrying the bits of all error events set in that cycle.
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         err_push_o <= 1'b0;
         err_code_o <= '0;
      end
      else
      begin
         err_push_o <= |(std_set & isevg_pkg::STD_ERR_MASK);
         err_code_o <= std_set & isevg_pkg::STD_ERR_MASK;
      end
   end

   // An execution error is pushed to the error queue in the next cycle.
   a_err_push: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      cond_i.exec_err |=> err_push_o && err_code_o[isevg_pkg::STD_EXE_BIT])
      else $error("execution error not pushed to error queue");

   // A query error is pushed to the error queue in the next cycle.
   a_qry_push: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      cond_i.query_err |=> err_push_o && err_code_o[isevg_pkg::STD_QRY_BIT])
      else $error("query error not pushed to error queue");

   // A device error is pushed to the error queue in the next cycle.
   a_dev_push: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      cond_i.device_err |=> err_push_o && err_code_o[isevg_pkg::STD_DEV_BIT])
      else $error("device error not pushed to error queue");

   // A command error is pushed to the error queue in the next cycle.
   a_cmd_push: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      cond_i.cmd_err |=> err_push_o && err_code_o[isevg_pkg::STD_CMD_BIT])
      else $error("command error not pushed to error queue");

   // The over-voltage event bit holds while no clear is issued.
   a_cond_latch: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cond_event[isevg_pkg::COND_OVP_BIT] && !cond_clr)
      |=> cond_event[isevg_pkg::COND_OVP_BIT])
      else $error("latched event bit dropped without clear");

   // The operation complete bit holds as well until it is cleared.
   a_std_latch: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (std_event[isevg_pkg::STD_OPC_BIT] && !std_clr) |=> std_event[isevg_pkg::STD_OPC_BIT])
      else $error("latched standard event bit dropped without clear");

   // A read with no concurrent set leaves the group empty.
   a_read_clears: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (std_clr && std_set == '0) |=> std_event == '0)
      else $error("standard event register not cleared");

   // Clear-status with no concurrent set empties the condition group.
   a_cls_clears: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (clear_status_i && cond_set == '0) |=> cond_event == '0)
      else $error("condition event register not cleared by clear status");

   // A set in the clearing cycle survives.
   a_set_wins: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cond_clr && cond_i.fan_fault) |=> cond_event[isevg_pkg::COND_FAN_BIT])
      else $error("event lost during clear");

   // Reset command and device clear leave events untouched.
   a_rst_keeps: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      ((reset_cmd_i || device_clear_i) && !std_clr)
      |=> std_event == ($past(std_event) | ($past(std_set) & isevg_pkg::STD_USED_MASK)))
      else $error("reset command disturbed events");

   // Clear-status keeps the condition enable mask.
   a_cls_enables: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (clear_status_i && !cond_en_wr) |=> cond_enable == $past(cond_enable))
      else $error("clear status changed enable register");

   // Clear-status keeps the standard enable mask as well.
   a_cls_std_en: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (clear_status_i && !std_en_wr && !std_en_pon_clr) |=> std_enable == $past(std_enable))
      else $error("clear status changed standard enable register");

   // Querying the condition enable register leaves it as it was.
   a_en_read_keep: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cmd_i.read && !cmd_i.write && cmd_i.sel == isevg_pkg::ISEVG_SEL_COND_ENABLE)
      |=> cond_enable == $past(cond_enable))
      else $error("enable query changed enable register");

   // Unused positions stay zero.
   a_unused_zero: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cond_event & ~isevg_pkg::COND_USED_MASK) == '0
      && (std_event & ~isevg_pkg::STD_USED_MASK) == '0)
      else $error("unused event bit set");

   // A standard event query answers with the pre-clear weighted sum.
   a_std_answer: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cmd_i.read && cmd_i.sel == isevg_pkg::ISEVG_SEL_STD_EVENT)
      |=> rvalid_o && rdata_o[CW-1:SW] == '0 && rdata_o[SW-1:0] == $past(std_event))
      else $error("standard event query answered wrongly");

   // No query means no answer and a zero data word.
   a_idle_answer: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      !cmd_i.read |=> !rvalid_o && rdata_o == '0)
      else $error("answer without a query");

   // The standard summary follows enabled events one cycle later.
   a_std_summary: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      pon_seen_q
      |=> summary_o[isevg_pkg::SUM_STD_BIT] == |($past(std_event) & $past(std_enable)))
      else $error("standard summary bit wrong");

   // The condition summary follows enabled events one cycle later.
   a_cond_summary: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      pon_seen_q
      |=> summary_o[isevg_pkg::SUM_COND_BIT] == |($past(cond_event) & $past(cond_enable)))
      else $error("condition summary bit wrong");

   // Writing zero empties the condition enable register.
   a_en_zero: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (cond_en_wr && cmd_i.wdata == '0) |=> cond_enable == '0)
      else $error("enable write of zero did not clear");

   // Writing zero empties the standard enable register.
   a_std_en_zero: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (std_en_wr && cmd_i.wdata[SW-1:0] == '0) |=> std_enable == '0)
      else $error("standard enable write of zero did not clear");

   // Power-on with the retained setting at one clears the standard enable.
   a_pon_clear: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (resetn_i && pon_pending_q && power_on_clear_i) |=> std_enable == '0)
      else $error("standard enable not cleared at power-on");

   // Power-on with the retained setting at zero keeps the standard enable.
   a_pon_keep: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (resetn_i && pon_pending_q && !power_on_clear_i && !std_en_wr)
      |=> std_enable == $past(std_enable))
      else $error("standard enable lost at power-on");

   // The first cycle after power-on raises the power-on event.
   a_pon_event: assert property (
      @(posedge clock_i) disable iff (!resetn_i)
      (resetn_i && pon_pending_q) |=> std_event[isevg_pkg::STD_PON_BIT])
      else $error("power-on event not raised");

endmodule : isevg_top

// ===== src/isevg_pkg.sv
// Package for the instrument status event groups block.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
package isevg_pkg;

   // Register widths.
   localparam int COND_W = 16;
   localparam int STD_W = 8;

   // Instrument-condition event bit positions.
   localparam int COND_VREG_BIT = 0;
   localparam int COND_IREG_BIT = 1;
   localparam int COND_FAN_BIT = 4;
   localparam int COND_OVP_BIT = 9;

   // Standard event bit positions.
   localparam int STD_OPC_BIT = 0;
   localparam int STD_QRY_BIT = 2;
   localparam int STD_DEV_BIT = 3;
   localparam int STD_EXE_BIT = 4;
   localparam int STD_CMD_BIT = 5;
   localparam int STD_PON_BIT = 7;

   // Masks of the implemented positions (every other position reads zero) and of the error events.
   localparam logic [COND_W-1:0] COND_USED_MASK = 16'h0213;
   localparam logic [STD_W-1:0] STD_USED_MASK = 8'hBD;
   localparam logic [STD_W-1:0] STD_ERR_MASK = 8'h3C;

   // Status summary bit positions driven by this block.
   localparam int SUM_COND_BIT = 3;
   localparam int SUM_STD_BIT = 5;

   // Reset values.
   localparam logic [COND_W-1:0] COND_RESET = 16'h0000;
   localparam logic [STD_W-1:0] STD_RESET = 8'h00;

   // Register selector carried with each remote command.
   typedef enum logic [1:0]
   {
      ISEVG_SEL_COND_EVENT,
      ISEVG_SEL_COND_ENABLE,
      ISEVG_SEL_STD_EVENT,
      ISEVG_SEL_STD_ENABLE
   } isevg_sel_e;

   // One command from the remote controller.
   typedef struct packed
   {
      logic read;
      logic write;
      isevg_sel_e sel;
      logic [COND_W-1:0] wdata;
   } isevg_cmd_s;

   // Raw condition pulses from the rest of the instrument.
   typedef struct packed
   {
      logic volt_unreg;
      logic curr_unreg;
      logic fan_fault;
      logic ovp_trip;
      logic op_complete;
      logic query_err;
      logic device_err;
      logic exec_err;
      logic cmd_err;
   } isevg_cond_s;

endpackage : isevg_pkg

// ===== src/isevg_group.sv
// One event group: latched event bits, an enable mask and its summary bit.
// Assumes the parent supplies already-positioned set pulses and clear strobes.
module isevg_group #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] USED = '1
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic clear_i,
   input wire logic en_wr_i,
   input wire logic [WIDTH-1:0] en_wdata_i,
   input wire logic en_clr_i,
   output logic [WIDTH-1:0] event_o,
   output logic [WIDTH-1:0] enable_o,
   output logic summary_o
);

   logic [WIDTH-1:0] event_q;
   logic [WIDTH-1:0] enable_q;

   // Event bits latch and hold; a set in the clearing cycle survives.
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         event_q <= '0;
      else if (clear_i)
         event_q <= set_i & USED;
      else
         event_q <= (event_q | set_i) & USED;
   end

   // Enable mask is written by command or cleared by en_clr_i only; reading never changes it.
   always_ff @(posedge clock_i)
   begin
      if (en_clr_i)
         enable_q <= '0;
      else if (en_wr_i)
         enable_q <= en_wdata_i & USED;
   end

   assign event_o = event_q;
   assign enable_o = enable_q;
   // Summary is the OR of enabled event bits.
   assign summary_o = |(event_q & enable_q);

endmodule : isevg_group

// ===== test/isevg_ctrl.sv
// Remote controller model that issues register queries and writes.
// Assumes the bench calls its tasks and that cmd_o feeds isevg_top.
module isevg_ctrl (
   input wire logic clock_i,
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   output isevg_pkg::isevg_cmd_s cmd_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // The bus starts idle.
   initial
   begin
      cmd_o = '0;
   end

   // Writes a mask given as the summed weights of the wanted bits.
   task automatic wr(input logic [1:0] s, input logic [15:0] d);
      @(posedge clock_i);
      cmd_o <= '{1'b0, 1'b1, isevg_pkg::isevg_sel_e'(s), d};
      @(posedge clock_i);
      cmd_o <= '{1'b0, 1'b0, isevg_pkg::isevg_sel_e'(s), ~d};
   endtask : wr

   // Issues a query, then waits a bounded time for the answer.
   task automatic rd(input logic [1:0] s, output logic [15:0] d, output bit ok);
      ok = 1'b0;
      d = '0;
      @(posedge clock_i);
      cmd_o <= '{1'b1, 1'b0, isevg_pkg::isevg_sel_e'(s), 16'hA5A5};
      @(posedge clock_i);
      cmd_o <= '{1'b0, 1'b0, isevg_pkg::isevg_sel_e'(s), 16'h5A5A};
      for (int n = 0; n < 4 && !ok; n++)
      begin
         #1;
         if (rvalid_i === 1'b1)
         begin
            ok = 1'b1;
            d = rdata_i;
         end
         else
            @(posedge clock_i);
      end
   endtask : rd
endmodule : isevg_ctrl

// ===== test/test_instrument_status_event_groups.sv
// Self-checking bench for the status event groups.
// Assumes isevg_pkg, isevg_top and isevg_ctrl are compiled first.
module test_instrument_status_event_groups;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed
   {
      logic [8:0] c;
      logic [1:0] s;
      logic [15:0] e;
   } isevg_row_s;
   localparam isevg_row_s ROWS [11] = '{
      '{9'h100, 2'h0, 16'h0001},
      '{9'h080, 2'h0, 16'h0002},
      '{9'h040, 2'h0, 16'h0010},
      '{9'h020, 2'h0, 16'h0200},
      '{9'h1E0, 2'h0, 16'h0213},
      '{9'h010, 2'h2, 16'h0001},
      '{9'h008, 2'h2, 16'h0004},
      '{9'h004, 2'h2, 16'h0008},
      '{9'h002, 2'h2, 16'h0010},
      '{9'h001, 2'h2, 16'h0020},
      '{9'h01F, 2'h2, 16'h003D}};
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic clr_st = 1'b0;
   logic dev_clr = 1'b0;
   logic rst_cmd = 1'b0;
   logic poc = 1'b0;
   logic [8:0] cond = '0;
   isevg_pkg::isevg_cmd_s cmd;
   logic [15:0] rdata;
   logic rvalid;
   logic [7:0] summary;
   logic err_push;
   logic [7:0] err_code;
   int failures = 0;
   int compares = 0;
   logic [15:0] d;
   bit ok;

   // Clock of 100 ns period.
   initial
   begin
      forever #50 clock = ~clock;
   end

   isevg_top i_dut (.clock_i(clock), .resetn_i(resetn), .cmd_i(cmd),
      .clear_status_i(clr_st), .device_clear_i(dev_clr), .reset_cmd_i(rst_cmd),
      .power_on_clear_i(poc), .cond_i(cond), .rdata_o(rdata), .rvalid_o(rvalid),
      .summary_o(summary), .err_push_o(err_push), .err_code_o(err_code));
   isevg_ctrl i_ctrl (.clock_i(clock), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_o(cmd));

   // Compares and counts one value.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // Reads a register and compares it; a missing answer ends the run.
   task automatic rc(input logic [1:0] s, input logic [15:0] e);
      i_ctrl.rd(s, d, ok);
      if (!ok)
      begin
         failures++;
         stop_test();
      end
      else
         chk(d, e);
   endtask : rc

   // Raises condition inputs for one cycle.
   task automatic pulse(input logic [8:0] c);
      @(posedge clock);
      cond <= c;
      @(posedge clock);
      cond <= '0;
   endtask : pulse

   // Holds reset for three cycles with the given power-on-clear setting.
   task automatic rst(input logic p);
      @(posedge clock);
      resetn <= 1'b0;
      poc <= p;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
   endtask : rst

   // Lets the registered summary settle.
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask : settle

   // Power-on checks first, then the table of single and combined events, then the hand-written cases.
   initial
   begin
      // First power-on uses the clearing setting so the standard enable is known.
      rst(1'b1);
      rc(2'h2, 16'h0080);
      rc(2'h2, 16'h0000);
      i_ctrl.wr(2'h1, 16'h0000);
      rc(2'h1, 16'h0000);
      i_ctrl.wr(2'h3, 16'h0000);
      foreach (ROWS[i])
      begin
         pulse(ROWS[i].c);
         repeat (2) @(posedge clock);
         rc(ROWS[i].s, ROWS[i].e);
         rc(ROWS[i].s, 16'h0000);
      end
      pulse(9'h002);
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         #1;
         if (err_push === 1'b1)
            ok = 1'b1;
         else
            @(posedge clock);
      end
      chk({15'h0000, ok}, 16'h0001);
      chk({8'h00, err_code}, 16'h0010);
      if (!ok)
         stop_test();
      rc(2'h2, 16'h0010);
      i_ctrl.wr(2'h1, 16'h0210);
      rc(2'h1, 16'h0210);
      rc(2'h1, 16'h0210);
      pulse(9'h040);
      settle();
      chk({8'h00, summary}, 16'h0008);
      i_ctrl.wr(2'h3, 16'h0001);
      pulse(9'h010);
      settle();
      chk({8'h00, summary}, 16'h0028);
      @(posedge clock);
      dev_clr <= 1'b1;
      rst_cmd <= 1'b1;
      @(posedge clock);
      dev_clr <= 1'b0;
      rst_cmd <= 1'b0;
      settle();
      chk({8'h00, summary}, 16'h0028);
      @(posedge clock);
      clr_st <= 1'b1;
      @(posedge clock);
      clr_st <= 1'b0;
      settle();
      chk({8'h00, summary}, 16'h0000);
      rc(2'h1, 16'h0210);
      rc(2'h3, 16'h0001);
      rc(2'h0, 16'h0000);
      fork
         rc(2'h0, 16'h0000);
         pulse(9'h020);
      join
      rc(2'h0, 16'h0200);
      i_ctrl.wr(2'h3, 16'h0020);
      rst(1'b0);
      rc(2'h3, 16'h0020);
      rst(1'b1);
      rc(2'h3, 16'h0000);
      stop_test();
   end
endmodule : test_instrument_status_event_groups
